// *** src/bcs_top.v ***
/*
  Board control/status register bank on a byte-wide device-bus chip select.
  Holds status one, status two, reset control and module presence.
  Assumes the device bus gives a one-cycle strobe per access, synchronous to
  clock, and that all board pins are asynchronous levels.
*/
`timescale 1ns/1ps
`include "bcs_regs.vh"
module bcs_top #(
  parameter REF_DIV       = `BCS_REF_DIV,
  parameter HARD_RST_CYC  = `BCS_HARD_RST_CYC
) (
  clock,
  rst,
  devCs,
  devRd,
  devWr,
  devAddr,
  devWrData,
  devRdData,
  devAck,
  uartOsc,
  bootBankJumper,
  safeStartJumper,
  abortSwitchN,
  flashStatusA,
  flashStatusB,
  fuseOk,
  busASpeedStrap,
  busCSpeedStrap,
  thermostatLevel,
  expansionModuleAbsent,
  slotTwoAbsent,
  slotOneAbsent,
  failLedDrive,
  eepromWriteProtect,
  flashWriteProtect,
  generalPurposeInputThermo,
  abortIrq,
  boardHardResetRequest
);
  input  wire                   clock;
  input  wire                   rst;
  input  wire                   devCs;
  input  wire                   devRd;
  input  wire                   devWr;
  input  wire [`BCS_ADDR_W-1:0] devAddr;
  input  wire [7:0]             devWrData;
  output wire [7:0]             devRdData;
  output wire                   devAck;
  input  wire                   uartOsc;
  input  wire                   bootBankJumper;
  input  wire                   safeStartJumper;
  input  wire                   abortSwitchN;
  input  wire                   flashStatusA;
  input  wire                   flashStatusB;
  input  wire                   fuseOk;
  input  wire                   busASpeedStrap;
  input  wire                   busCSpeedStrap;
  input  wire                   thermostatLevel;
  input  wire                   expansionModuleAbsent;
  input  wire                   slotTwoAbsent;
  input  wire                   slotOneAbsent;
  output wire                   failLedDrive;
  output wire                   eepromWriteProtect;
  output wire                   flashWriteProtect;
  output wire                   generalPurposeInputThermo;
  output wire                   abortIrq;
  output wire                   boardHardResetRequest;

  // ----------------------------------------------------------------------
  // local sizes
  // ----------------------------------------------------------------------
  localparam REF_HALF     = REF_DIV / 2;
  localparam REF_CNT_W    = 6;
  localparam HRST_CNT_W   = 8;
  localparam integer          REF_LAST_I  = REF_HALF - 1;
  localparam integer          HRST_LAST_I = HARD_RST_CYC - 1;
  localparam [REF_CNT_W-1:0]  REF_LAST  = REF_LAST_I[REF_CNT_W-1:0];
  localparam [HRST_CNT_W-1:0] HRST_LAST = HRST_LAST_I[HRST_CNT_W-1:0];
  localparam [3:0]            RST_S2    = `BCS_RST_S2_CTRL; // status two bits 7:4
  localparam [7:0]            RST_S3    = `BCS_RST_S3;

  // ----------------------------------------------------------------------
  // synchronised board levels
  // ----------------------------------------------------------------------
  wire [12:0] pinsRaw;
  wire [12:0] pinsSync;

  wire oscSync;
  wire bootBankSync;
  wire safeStartSync;
  wire abortSwitchSync;
  wire flashBusySyncA;
  wire flashBusySyncB;
  wire fuseOkSync;
  wire busASpeedSync;
  wire busCSpeedSync;
  wire thermostatSync;
  wire [2:0] absentSync;

  // pin order matches the reset vector in the header; abort and absence
  // bits come up as 1 so nothing looks pressed or fitted before sampling
  assign pinsRaw = {expansionModuleAbsent, slotTwoAbsent, slotOneAbsent,
                    abortSwitchN, uartOsc, bootBankJumper, safeStartJumper,
                    flashStatusA, flashStatusB, fuseOk, busASpeedStrap,
                    busCSpeedStrap, thermostatLevel};

  // every pin passes two flops before any logic looks at it
  bcs_sync #(
    .WIDTH     (13),
    .RESET_VAL (`BCS_SYNC_RESET)
  ) pinSync (
    .clock      (clock),
    .rst        (rst),
    .rawBits    (pinsRaw),
    .stableBits (pinsSync)
  );

  assign absentSync      = pinsSync[12:10];
  assign abortSwitchSync = pinsSync[9];
  assign oscSync         = pinsSync[8];
  assign bootBankSync    = pinsSync[7];
  assign safeStartSync   = pinsSync[6];
  assign flashBusySyncA  = pinsSync[5];
  assign flashBusySyncB  = pinsSync[4];
  assign fuseOkSync      = pinsSync[3];
  assign busASpeedSync   = pinsSync[2];
  assign busCSpeedSync   = pinsSync[1];
  assign thermostatSync  = pinsSync[0];

  // ----------------------------------------------------------------------
  // reference clock divider
  // ----------------------------------------------------------------------
  reg                 oscPrev_q;
  reg [REF_CNT_W-1:0] refCnt_q;
  reg                 refClk_q;
  wire                oscRise;

  // the oscillator is far below clock, so a rising edge is seen cleanly
  // once per oscillator period after synchronising
  assign oscRise = oscSync & ~oscPrev_q;

  // toggle every half of the division ratio: a full period is REF_DIV edges
  always @(posedge clock)
  begin
    if (rst)
    begin
      oscPrev_q <= 1'b0;
      refCnt_q  <= {REF_CNT_W{1'b0}};
      refClk_q  <= 1'b0;
    end
    else
    begin
      oscPrev_q <= oscSync;
      if (oscRise)
      begin
        if (refCnt_q == REF_LAST)
        begin
          refCnt_q <= {REF_CNT_W{1'b0}};
          refClk_q <= ~refClk_q;
        end
        else
        begin
          refCnt_q <= refCnt_q + 6'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  reg selS1;
  reg selS2;
  reg selS3;
  reg selPres;

  // only the mapped offsets of the window are selected; offset 3 and everything
  // above the presence register decode to nothing, though every access is acknowledged
  always @*
  begin
    selS1   = 1'b0;
    selS2   = 1'b0;
    selS3   = 1'b0;
    selPres = 1'b0;
    if (devAddr == `BCS_OFF_STATUS_ONE)
      selS1 = 1'b1;
    else if (devAddr == `BCS_OFF_STATUS_TWO)
      selS2 = 1'b1;
    else if (devAddr == `BCS_OFF_RESET_CTRL)
      selS3 = 1'b1;
    else if (devAddr == `BCS_OFF_PRESENCE)
      selPres = 1'b1;
  end

  wire wrStb;
  wire rdStb;

  assign wrStb = devCs & devWr;
  assign rdStb = devCs & devRd & ~devWr;

  // ----------------------------------------------------------------------
  // writable control state
  // ----------------------------------------------------------------------
  reg       swAbort_q;
  reg       failLed_q;
  reg       eepromWp_q;
  reg       flashWp_q;
  reg       tstatBlock_q;
  reg       abortBlock_q;
  reg       hardRst_q;
  reg [HRST_CNT_W-1:0] hardCnt_q;

  // only the documented writable bits are stored; all other bits of a
  // written byte are dropped
  always @(posedge clock)
  begin
    if (rst)
    begin
      swAbort_q    <= 1'b0;
      failLed_q    <= RST_S2[3];
      eepromWp_q   <= RST_S2[2];
      flashWp_q    <= RST_S2[1];
      tstatBlock_q <= RST_S2[0];
      abortBlock_q <= RST_S3[`BCS_S3_ABORT_BLOCK];
    end
    else if (wrStb)
    begin
      if (selS1)
        swAbort_q <= ~devWrData[`BCS_S1_ABORT];
      if (selS2)
      begin
        failLed_q    <= devWrData[`BCS_S2_FAIL_LED];
        eepromWp_q   <= devWrData[`BCS_S2_EEPROM_WP];
        flashWp_q    <= devWrData[`BCS_S2_FLASH_WP];
        tstatBlock_q <= devWrData[`BCS_S2_TSTAT_BLOCK];
      end
      if (selS3)
        abortBlock_q <= devWrData[`BCS_S3_ABORT_BLOCK];
    end
  end

  // ----------------------------------------------------------------------
  // self-clearing board hard reset
  // ----------------------------------------------------------------------
  // the request is held for a fixed number of cycles and then drops; a
  // second write while it runs does not extend it
  always @(posedge clock)
  begin
    if (rst)
    begin
      hardRst_q <= 1'b0;
      hardCnt_q <= {HRST_CNT_W{1'b0}};
    end
    else if (hardRst_q)
    begin
      if (hardCnt_q == HRST_LAST)
      begin
        hardRst_q <= 1'b0;
        hardCnt_q <= {HRST_CNT_W{1'b0}};
      end
      else
      begin
        hardCnt_q <= hardCnt_q + 8'h01;
      end
    end
    else if (wrStb & selS3 & devWrData[`BCS_S3_HARD_RESET])
    begin
      hardRst_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt and control outputs
  // ----------------------------------------------------------------------
  reg abortIrq_q;
  reg thermoIrq_q;

  // a pressed switch or a software request raises abort unless blocked
  always @(posedge clock)
  begin
    if (rst)
    begin
      abortIrq_q  <= 1'b0;
      thermoIrq_q <= 1'b0;
    end
    else
    begin
      abortIrq_q  <= (~abortSwitchSync | swAbort_q) & ~abortBlock_q;
      thermoIrq_q <= thermostatSync & ~tstatBlock_q;
    end
  end

  assign abortIrq                  = abortIrq_q;
  assign generalPurposeInputThermo = thermoIrq_q;
  assign failLedDrive              = failLed_q;
  assign eepromWriteProtect        = eepromWp_q;
  assign flashWriteProtect         = flashWp_q;
  assign boardHardResetRequest     = hardRst_q;

  // ----------------------------------------------------------------------
  // read data assembly
  // ----------------------------------------------------------------------
  reg [7:0] readMux;

  // reserved bits are constants here, so writes can never reach them
  always @*
  begin
    readMux = `BCS_READ_NONE;
    if (selS1)
    begin
      readMux[`BCS_S1_REF_CLK]    = refClk_q;
      readMux[`BCS_S1_BOOT_BANK]  = bootBankSync;
      readMux[`BCS_S1_SAFE_START] = safeStartSync;
      readMux[`BCS_S1_ABORT]      = abortSwitchSync;
      readMux[`BCS_S1_FLASH_BUSY] = flashBusySyncA | flashBusySyncB;
      readMux[`BCS_S1_FUSE_OK]    = fuseOkSync;
    end
    else if (selS2)
    begin
      readMux[`BCS_S2_FAIL_LED]    = failLed_q;
      readMux[`BCS_S2_EEPROM_WP]   = eepromWp_q;
      readMux[`BCS_S2_FLASH_WP]    = flashWp_q;
      readMux[`BCS_S2_TSTAT_BLOCK] = tstatBlock_q;
      readMux[`BCS_S2_BUS_B_SPEED] = 1'b0;
      readMux[`BCS_S2_BUS_C_SPEED] = busCSpeedSync;
      readMux[`BCS_S2_BUS_A_SPEED] = busASpeedSync;
    end
    else if (selS3)
    begin
      readMux[`BCS_S3_HARD_RESET]  = hardRst_q;
      readMux[`BCS_S3_ABORT_BLOCK] = abortBlock_q;
    end
    else if (selPres)
    begin
      readMux = {`BCS_PRES_RSVD, absentSync};
    end
  end

  // ----------------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------------
  reg [7:0] rdData_q;
  reg       ack_q;

  // read data are captured at the strobe edge and held until the next
  // read, so the host may sample them late without glitches
  always @(posedge clock)
  begin
    if (rst)
    begin
      rdData_q <= `BCS_READ_NONE;
      ack_q    <= 1'b0;
    end
    else
    begin
      ack_q <= wrStb | rdStb;
      if (rdStb)
        rdData_q <= readMux;
    end
  end

  assign devRdData = rdData_q;
  assign devAck    = ack_q;
endmodule

// *** pkg/bcs_regs.vh ***
/*
  Board control/status register bank: offsets, bit positions, reset values
  and timing counts shared by the design files.
  Assumes it is included by bare name from files under src/.
*/
// Overview of operation
// - status one bit 7 shows live reference clock, serial oscillator divided by 64.
// - boot bank bit follows jumper; 0 bank 0 boots, 1 bank 1 boots.
// - safe start bit follows jumper; 1 asks firmware for safe default settings.
// - writing 0 to abort bit asserts abort interrupt; writing 1 clears it.
// - reading abort bit gives switch: 1 released, 0 pressed; resets to 1.
// - flash busy bit reads wired-OR of two flash bank 0 status pins.
// - fuse bit reads 1 when all fuses intact, 0 when any is open.
// - fail bit drives front-panel fail LED directly; set lights it; resets 1.
// - EEPROM write-protect bit protects EEPROMs while set; resets set.
// - flash write-protect bit protects both banks, set by reset; software clears.
// - thermostat mask clear passes thermostat to general-purpose input; set blocks.
// - bus A and bus C speed bits follow their 66 MHz pins; 0 is 33, 1 is 66.
// - speed bit for secondary bus, bit 2 of status two, always reads 0.
// - writing 1 to board reset bit forces hard reset; bit self-clears after.
// - abort mask set blocks abort interrupt; clear allows it; resets to 1.
// - three presence bits read 1 when module absent, 0 when fitted.
// - registers decode as byte offsets in 1MB window; offset 3 reserved.
`ifndef BCS_REGS_VH
`define BCS_REGS_VH

// ----------------------------------------------------------------------
// window and register offsets
// ----------------------------------------------------------------------
`define BCS_ADDR_W         20
`define BCS_OFF_STATUS_ONE 20'h00000
`define BCS_OFF_STATUS_TWO 20'h00001
`define BCS_OFF_RESET_CTRL 20'h00002
`define BCS_OFF_RESERVED3  20'h00003
`define BCS_OFF_PRESENCE   20'h00004

// ----------------------------------------------------------------------
// bit positions
// ----------------------------------------------------------------------
`define BCS_S1_REF_CLK     7
`define BCS_S1_BOOT_BANK   6
`define BCS_S1_SAFE_START  5
`define BCS_S1_ABORT       4
`define BCS_S1_FLASH_BUSY  3
`define BCS_S1_FUSE_OK     2
`define BCS_S2_FAIL_LED    7
`define BCS_S2_EEPROM_WP   6
`define BCS_S2_FLASH_WP    5
`define BCS_S2_TSTAT_BLOCK 4
`define BCS_S2_BUS_B_SPEED 2
`define BCS_S2_BUS_C_SPEED 1
`define BCS_S2_BUS_A_SPEED 0
`define BCS_S3_HARD_RESET  7
`define BCS_S3_ABORT_BLOCK 3

// ----------------------------------------------------------------------
// reset and fixed values
// ----------------------------------------------------------------------
`define BCS_RST_S2_CTRL    4'hf
`define BCS_RST_S3         8'h08
`define BCS_PRES_RSVD      5'h1f
`define BCS_READ_NONE      8'h00
`define BCS_SYNC_RESET     13'h1e00

// ----------------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------------
`define BCS_REF_DIV        64
`define BCS_HARD_RST_CYC   16

`endif

// *** src/bcs_sync.v ***
/*
  Two-flop synchroniser for a group of slow board levels.
  Assumes inputs are quasi-static pins; no bus coherence between bits.
*/
`timescale 1ns/1ps
module bcs_sync #(
  parameter WIDTH     = 13,
  parameter RESET_VAL = 13'h0000
) (
  clock,
  rst,
  rawBits,
  stableBits
);
  input  wire             clock;
  input  wire             rst;
  input  wire [WIDTH-1:0] rawBits;
  output wire [WIDTH-1:0] stableBits;

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] stable_q;

  // ----------------------------------------------------------------------
  // two stages; only the second stage is visible outside
  // ----------------------------------------------------------------------
  always @(posedge clock)
  begin
    if (rst)
    begin
      meta_q   <= RESET_VAL;
      stable_q <= RESET_VAL;
    end
    else
    begin
      meta_q   <= rawBits;
      stable_q <= meta_q;
    end
  end

  assign stableBits = stable_q;
endmodule

// *** dv/bcs_top_checker.sv ***
/*
  Port-level checker for bcs_top: bus answers, fixed read bits, control
  outputs, hard reset pulse and interrupt gating.
  Assumes it is bound to bcs_top and sees only that module's ports.
*/
`timescale 1ns/1ps
module bcs_top_checker #(
  parameter HARD_RST_CYC = 16
) (
  input wire        clock,
  input wire        rst,
  input wire        devCs,
  input wire        devRd,
  input wire        devWr,
  input wire        devAck,
  input wire        thermostatLevel,
  input wire [19:0] devAddr,
  input wire [7:0]  devWrData,
  input wire [7:0]  devRdData,
  input wire        failLedDrive,
  input wire        eepromWriteProtect,
  input wire        flashWriteProtect,
  input wire        generalPurposeInputThermo,
  input wire        abortIrq,
  input wire        boardHardResetRequest
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire       wrQ    = devCs && devWr;
  wire       rdQ    = devCs && devRd && !devWr;
  wire [2:0] ctrlIn = devWrData[7:5];
  reg  [7:0] hardCnt_q;
  // length of the request pulse, judged when it falls
  always @(posedge clock)
    if (rst || !boardHardResetRequest) hardCnt_q <= 8'h00;
    else hardCnt_q <= hardCnt_q + 8'h01;
  sequence hardStart;
    wrQ && devAddr == 20'h2 && devWrData[7] && !boardHardResetRequest;
  endsequence
  sequence hardHeld;
    boardHardResetRequest;
  endsequence
  a_ack_follows_access: assert property (devCs && (devRd || devWr) |=> devAck)
    else $error("no acknowledge after an access");
  a_ack_has_cause: assert property (devAck |-> $past(devCs) && ($past(devRd) || $past(devWr)))
    else $error("acknowledge without an access");
  a_unmapped_reads_zero: assert property (rdQ && (devAddr == 20'h3 || devAddr > 20'h4)
    |=> devRdData == 8'h00)
    else $error("unmapped offset read not zero");
  a_presence_upper_ones: assert property (rdQ && devAddr == 20'h4 |=> devRdData[7:3] == 5'h1f)
    else $error("presence reserved bits not ones");
  a_status_two_fixed: assert property (rdQ && devAddr == 20'h1 |=> devRdData[3:2] == 2'b00)
    else $error("status two fixed bits not zero");
  a_ctrl_write_outputs: assert property (wrQ && devAddr == 20'h1 |=>
    {failLedDrive, eepromWriteProtect, flashWriteProtect} == $past(ctrlIn))
    else $error("control outputs do not follow write");
  a_hard_reset_start: assert property (hardStart |=> hardHeld)
    else $error("hard reset request not raised");
  a_hard_reset_length: assert property ($fell(boardHardResetRequest) |-> hardCnt_q == HARD_RST_CYC)
    else $error("hard reset pulse length wrong");
  a_abort_mask_blocks: assert property (wrQ && devAddr == 20'h2 && devWrData[3] |-> ##2 !abortIrq)
    else $error("abort interrupt not masked");
  a_thermo_needs_pin: assert property (generalPurposeInputThermo |-> $past(thermostatLevel, 3))
    else $error("thermostat output without thermostat");
  a_reset_leaves_defaults: assert property ($fell(rst) |-> failLedDrive && eepromWriteProtect
    && flashWriteProtect && !abortIrq && !boardHardResetRequest)
    else $error("outputs wrong after reset");
endmodule
bind bcs_top bcs_top_checker #(.HARD_RST_CYC(HARD_RST_CYC)) bcs_top_checker_i (.*);

// *** dv/bcs_host_model.sv ***
/*
  Host side of the device bus: one-cycle read or write strobe per access.
  Assumes the bank acknowledges one cycle after taking the strobe.
*/
`timescale 1ns/1ps
module bcs_host_model (
  input  wire         clock,
  input  wire         devAck,
  input  wire  [7:0]  devRdData,
  output logic        devCs,
  output logic        devRd,
  output logic        devWr,
  output logic [19:0] devAddr,
  output logic [7:0]  devWrData
);
  initial {devCs, devRd, devWr, devAddr, devWrData} = 31'h0;
  // strobe for one edge, then take acknowledge and data just after the next
  task automatic access(input logic wr, input logic [19:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic ack);
    @(posedge clock);
    #1;
    {devCs, devRd, devWr, devAddr, devWrData} = {1'b1, !wr, wr, a, d};
    @(posedge clock);
    #1;
    ack = devAck;
    q = devRdData;
    // released lines show the inverse so stale values never pass as live
    {devCs, devRd, devWr, devAddr, devWrData} = {3'b000, ~a, ~d};
  endtask
endmodule

// *** dv/bcs_top_tb.sv ***
/*
  Self-checking bench for bcs_top: host model runs the bus, the bench drives
  board pins. Assumes a shortened hard reset count to keep the run brief.
*/
`timescale 1ns/1ps
module bcs_top_tb;
  localparam int HR = 2;
  logic        clock, rst, uartOsc, bootBankJumper, safeStartJumper, abortSwitchN;
  logic        flashStatusA, flashStatusB, fuseOk, busASpeedStrap, busCSpeedStrap;
  logic        thermostatLevel, expansionModuleAbsent, slotTwoAbsent, slotOneAbsent;
  logic        devCs, devRd, devWr, devAck, ackv, refv;
  logic [19:0] devAddr;
  logic [7:0]  devWrData, devRdData, rdv;
  logic        failLedDrive, eepromWriteProtect, flashWriteProtect;
  logic        generalPurposeInputThermo, abortIrq, boardHardResetRequest;
  logic [9:0]  pins;
  int          n_fail, check_count, cyc;
  bcs_top #(.HARD_RST_CYC(HR)) bcs_top_i (.*);
  bcs_host_model bcs_host_model_i (.*);
  initial
  begin
    clock = 0;
    forever #50 clock = ~clock;
  end
  // hang guard: the whole run needs well under this many cycles
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      n_fail++;
      $display("FAIL timeout expected end seen hang");
      results;
    end
  end
  task automatic chk(string what, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic rd(logic [19:0] a, logic [7:0] e, logic [7:0] m, string what);
    bcs_host_model_i.access(1'b0, a, 8'h00, rdv, ackv);
    chk("read ack", 8'h01, {7'h0, ackv});
    chk(what, e & m, rdv & m);
  endtask
  task automatic wr(logic [19:0] a, logic [7:0] d);
    bcs_host_model_i.access(1'b1, a, d, rdv, ackv);
    chk("write ack", 8'h01, {7'h0, ackv});
  endtask
  task automatic settle();
    repeat (4) @(posedge clock);
    #1;
  endtask
  task automatic pulse(int n);
    repeat (2 * n)
    begin
      repeat (2) @(posedge clock);
      #1 uartOsc = ~uartOsc;
    end
  endtask
  task automatic t_reset();
    settle();
    rd(20'h0, 8'h14, 8'h7f, "status one");
    rd(20'h1, 8'hf1, 8'hff, "status two");
    rd(20'h2, 8'h08, 8'hff, "reset control");
    rd(20'h4, 8'hfd, 8'hff, "presence");
    chk("outputs", 8'h38, {2'b00, failLedDrive, eepromWriteProtect, flashWriteProtect,
        generalPurposeInputThermo, abortIrq, boardHardResetRequest});
    $display("test reset done");
  endtask
  task automatic t_pins();
    logic [9:0] v[3] = '{10'h2aa, 10'h155, 10'h000};
    foreach (v[i])
    begin
      pins = v[i];
      {bootBankJumper, safeStartJumper, flashStatusA, flashStatusB, fuseOk, busASpeedStrap,
       busCSpeedStrap, expansionModuleAbsent, slotTwoAbsent, slotOneAbsent} = pins;
      settle();
      rd(20'h0, {1'b0, pins[9:8], 1'b1, pins[7] | pins[6], pins[5], 2'b00}, 8'h7f, "status pins");
      rd(20'h1, {6'h3c, pins[3], pins[4]}, 8'hff, "speed pins");
      rd(20'h4, {5'h1f, pins[2:0]}, 8'hff, "presence pins");
    end
    $display("test pins done");
  endtask
  task automatic t_refclk();
    rd(20'h0, 8'h00, 8'h80, "ref sample");
    refv = rdv[7];
    pulse(32);
    settle();
    rd(20'h0, {~refv, 7'h0}, 8'h80, "ref after 32");
    pulse(31);
    settle();
    rd(20'h0, {~refv, 7'h0}, 8'h80, "ref after 63");
    pulse(1);
    settle();
    rd(20'h0, {refv, 7'h0}, 8'h80, "ref after 64");
    $display("test refclk done");
  endtask
  task automatic t_ctrl();
    wr(20'h1, 8'h0f);
    chk("ctrl low", 8'h00, {5'h0, failLedDrive, eepromWriteProtect, flashWriteProtect});
    rd(20'h1, 8'h00, 8'hff, "ctrl readback low");
    thermostatLevel = 1;
    wr(20'h1, 8'hf0);
    chk("ctrl high", 8'h07, {5'h0, failLedDrive, eepromWriteProtect, flashWriteProtect});
    settle();
    chk("thermo blocked", 8'h00, {7'h0, generalPurposeInputThermo});
    wr(20'h1, 8'he0);
    settle();
    chk("thermo passed", 8'h01, {7'h0, generalPurposeInputThermo});
    wr(20'h1, 8'hf0);
    settle();
    chk("thermo reblocked", 8'h00, {7'h0, generalPurposeInputThermo});
    $display("test ctrl done");
  endtask
  task automatic t_abort();
    wr(20'h0, 8'h00);
    settle();
    chk("abort masked", 8'h00, {7'h0, abortIrq});
    wr(20'h2, 8'h00);
    settle();
    chk("abort software", 8'h01, {7'h0, abortIrq});
    wr(20'h0, 8'h10);
    settle();
    chk("abort cleared", 8'h00, {7'h0, abortIrq});
    abortSwitchN = 0;
    settle();
    chk("abort switch", 8'h01, {7'h0, abortIrq});
    rd(20'h0, 8'h00, 8'h10, "abort pressed");
    abortSwitchN = 1;
    wr(20'h2, 8'h08);
    settle();
    chk("abort remasked", 8'h00, {7'h0, abortIrq});
    $display("test abort done");
  endtask
  task automatic t_hard();
    wr(20'h2, 8'h88);
    chk("hard reset on", 8'h01, {7'h0, boardHardResetRequest});
    repeat (HR - 1) @(posedge clock);
    #1;
    chk("hard reset held", 8'h01, {7'h0, boardHardResetRequest});
    @(posedge clock);
    #1;
    chk("hard reset off", 8'h00, {7'h0, boardHardResetRequest});
    $display("test hard reset done");
  endtask
  task automatic t_unmapped();
    wr(20'h3, 8'hff);
    wr(20'h5, 8'hff);
    wr(20'h4, 8'h00);
    rd(20'h2, 8'h08, 8'hff, "reset ctrl kept");
    rd(20'h3, 8'h00, 8'hff, "offset 3");
    rd(20'h5, 8'h00, 8'hff, "offset 5");
    rd(20'hfffff, 8'h00, 8'hff, "window top");
    rd(20'h4, 8'hf8, 8'hff, "presence kept");
    $display("test unmapped done");
  endtask
  task automatic results();
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    {uartOsc, bootBankJumper, safeStartJumper, flashStatusA, flashStatusB} = 5'h0;
    {busCSpeedStrap, thermostatLevel, slotTwoAbsent} = 3'h0;
    {abortSwitchN, fuseOk, busASpeedStrap, expansionModuleAbsent, slotOneAbsent} = 5'h1f;
    rst = 1;
    repeat (2) @(posedge clock);
    #1 rst = 0;
    t_reset();
    t_pins();
    t_refclk();
    t_ctrl();
    t_abort();
    t_hard();
    t_unmapped();
    results();
  end
endmodule
